// >>> hdl/timer8_core.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module timer8_core
  import timer8_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       external_count_pin,
  input  wire logic       global_interrupt_enable,
  input  wire logic [2:0] vector_ack,
  output logic            irq_overflow,
  output logic            irq_compare_a,
  output logic            irq_compare_b,
  output logic            compare_a_output_pin,
  output logic            compare_b_output_pin
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [1:0]       com_a_q, com_b_q, wgm_low_q;
  logic             wgm2_q;
  logic [2:0]       cs_q;
  logic [2:0]       mask_q;
  logic [2:0]       flags_q;
  logic [2:0]       flags_d;
  logic [2:0]       irq_q;
  logic [7:0]       cnt_q, cnt_d;
  logic [7:0]       cmp_a_buf_q, cmp_b_buf_q;
  logic [7:0]       cmp_a_act_q, cmp_b_act_q;
  logic             dir_down_q, dir_d;
  logic             block_q;
  logic [PRE_W-1:0] pre_q;
  logic             ext_s1_q, ext_s2_q, ext_s3_q;
  logic [1:0]       wave_q, wave_d;
  logic [7:0]       rd_data_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire wr_ctrl_a = wr_en && addr == OFF_CTRL_A;
  wire wr_ctrl_b = wr_en && addr == OFF_CTRL_B;
  wire wr_cnt    = wr_en && addr == OFF_COUNTER;
  wire wr_cmp_a  = wr_en && addr == OFF_CMP_A;
  wire wr_cmp_b  = wr_en && addr == OFF_CMP_B;
  wire wr_flags  = wr_en && addr == OFF_FLAGS;
  wire wr_mask   = wr_en && addr == OFF_MASK;

  wave_mode_e mode;
  assign mode = wave_mode_e'({wgm2_q, wgm_low_q});

  wire is_pc   = mode == MODE_PC_FF || mode == MODE_PC_TOP;
  wire is_fast = mode == MODE_FAST_FF || mode == MODE_FAST_TOP;
  wire non_pwm = !is_pc && !is_fast;
  wire top_is_a = mode == MODE_CTC || mode == MODE_PC_TOP || mode == MODE_FAST_TOP;

  // non-PWM compare values take effect at once
  wire [7:0] cmp_a_eff = non_pwm ? cmp_a_buf_q : cmp_a_act_q;
  wire [7:0] cmp_b_eff = non_pwm ? cmp_b_buf_q : cmp_b_act_q;
  wire [7:0] top       = top_is_a ? cmp_a_eff : CNT_MAX;

  // ----------------------------------------
  // clock select
  // ----------------------------------------
  wire ext_rise = ext_s2_q && !ext_s3_q;
  wire ext_fall = !ext_s2_q && ext_s3_q;

  logic tick;
  always_comb begin
    unique case (clk_sel_e'(cs_q))
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (pre_q & DIV8_MASK) == DIV8_MASK;
      CS_DIV64:    tick = (pre_q & DIV64_MASK) == DIV64_MASK;
      CS_DIV256:   tick = (pre_q & DIV256_MASK) == DIV256_MASK;
      CS_DIV1024:  tick = pre_q == DIV1024_MASK;
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
    endcase
  end

  // ----------------------------------------
  // counter sequence
  // ----------------------------------------
  wire at_top    = cnt_q == top;
  wire at_bot    = cnt_q == CNT_BOT;
  wire cnt_wrap  = (mode == MODE_CTC || is_fast) && at_top;
  wire turn_down = is_pc && !dir_down_q && at_top;
  wire turn_up   = is_pc && dir_down_q && at_bot;
  wire go_down   = turn_down || (is_pc && dir_down_q && !turn_up);

  wire [7:0] cnt_step = cnt_wrap ? CNT_BOT : go_down ? cnt_q - 8'h01 : cnt_q + 8'h01;

  assign dir_d = !is_pc ? 1'b0 : (tick && turn_down) ? 1'b1 : (tick && turn_up) ? 1'b0 : dir_down_q;
  assign cnt_d = wr_cnt ? wr_data : tick ? cnt_step : cnt_q;

  // double buffered compare values load at TOP in both PWM modes
  wire cmp_load = non_pwm || (tick && (turn_down || (is_fast && at_top)));

  // ----------------------------------------
  // events
  // ----------------------------------------
  wire hit_a = tick && !block_q && cnt_q == cmp_a_eff;
  wire hit_b = tick && !block_q && cnt_q == cmp_b_eff;
  wire ovf_evt = tick && (is_pc ? turn_up : is_fast ? at_top : cnt_q == CNT_MAX);
  wire bot_evt = tick && is_fast && at_top;

  // forces act only outside PWM; software keeps them zero there
  wire force_a = wr_ctrl_b && wr_data[FORCE_A_BIT] && non_pwm;
  wire force_b = wr_ctrl_b && wr_data[FORCE_B_BIT] && non_pwm;

  wire [2:0] flag_set = {hit_b, hit_a, ovf_evt};
  wire [2:0] flag_clr = (wr_flags ? wr_data[2:0] : 3'b000) | vector_ack;

  // ----------------------------------------
  // flags, per source
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_src
      // set wins over a clear in the same cycle
      assign flags_d[gi] = flag_set[gi] || (flags_q[gi] && !flag_clr[gi]);
    end
  endgenerate

  // ----------------------------------------
  // waveform outputs, per channel
  // ----------------------------------------
  wire [1:0] ch_hit   = {hit_b, hit_a};
  wire [1:0] ch_force = {force_b, force_a};
  wire [1:0] ch_com [2];
  assign ch_com[0] = com_a_q;
  assign ch_com[1] = com_b_q;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_wave
      // channel A alone may toggle in PWM when top comes from its compare
      wire tog_ok = (gi == 0) && wgm2_q;
      always_comb begin
        wave_d[gi] = wave_q[gi];
        if (non_pwm) begin
          if (ch_hit[gi] || ch_force[gi]) begin
            unique case (ch_com[gi])
              2'b01:   wave_d[gi] = !wave_q[gi];
              2'b10:   wave_d[gi] = 1'b0;
              2'b11:   wave_d[gi] = 1'b1;
              default: wave_d[gi] = wave_q[gi];
            endcase
          end
        end else if (ch_com[gi][1]) begin
          if (ch_hit[gi])
            wave_d[gi] = is_pc ? (ch_com[gi][0] ^ dir_down_q) : ch_com[gi][0];
          else if (bot_evt)
            wave_d[gi] = !ch_com[gi][0];
        end else if (ch_com[gi][0] && tog_ok && ch_hit[gi]) begin
          wave_d[gi] = !wave_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [7:0] rd_ctrl_a = {com_a_q, com_b_q, 2'b00, wgm_low_q};
  wire [7:0] rd_ctrl_b = {4'h0, wgm2_q, cs_q};
  wire [7:0] rd_mux =
    addr == OFF_CTRL_A  ? rd_ctrl_a :
    addr == OFF_CTRL_B  ? rd_ctrl_b :
    addr == OFF_COUNTER ? cnt_q :
    addr == OFF_CMP_A   ? cmp_a_buf_q :
    addr == OFF_CMP_B   ? cmp_b_buf_q :
    addr == OFF_FLAGS   ? {5'h00, flags_q} :
    addr == OFF_MASK    ? {5'h00, mask_q} :
    8'h00;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      com_a_q   <= 2'h0;
      com_b_q   <= 2'h0;
      wgm_low_q <= 2'h0;
      wgm2_q    <= 1'b0;
      cs_q      <= 3'h0;
      mask_q    <= 3'h0;
    end else begin
      if (wr_ctrl_a) begin
        com_a_q   <= wr_data[COM_A_LSB +: 2];
        com_b_q   <= wr_data[COM_B_LSB +: 2];
        wgm_low_q <= wr_data[WGM_LOW_LSB +: 2];
      end
      if (wr_ctrl_b) begin
        wgm2_q <= wr_data[WGM2_BIT];
        cs_q   <= wr_data[CS_LSB +: 3];
      end
      if (wr_mask)
        mask_q <= wr_data[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q       <= RESET_VAL;
      dir_down_q  <= 1'b0;
      block_q     <= 1'b0;
      pre_q       <= '0;
      cmp_a_buf_q <= RESET_VAL;
      cmp_b_buf_q <= RESET_VAL;
      cmp_a_act_q <= RESET_VAL;
      cmp_b_act_q <= RESET_VAL;
    end else begin
      cnt_q      <= cnt_d;
      dir_down_q <= dir_d;
      block_q    <= wr_cnt || (block_q && !tick);
      pre_q      <= pre_q + 10'h001;
      if (wr_cmp_a)
        cmp_a_buf_q <= wr_data;
      if (wr_cmp_b)
        cmp_b_buf_q <= wr_data;
      if (cmp_load) begin
        cmp_a_act_q <= cmp_a_buf_q;
        cmp_b_act_q <= cmp_b_buf_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q   <= 3'h0;
      irq_q     <= 3'h0;
      wave_q    <= 2'h0;
      rd_data_q <= 8'h00;
      ext_s1_q  <= 1'b0;
      ext_s2_q  <= 1'b0;
      ext_s3_q  <= 1'b0;
    end else begin
      flags_q   <= flags_d;
      irq_q     <= flags_q & mask_q & {3{global_interrupt_enable}};
      wave_q    <= wave_d;
      rd_data_q <= rd_en ? rd_mux : 8'h00;
      ext_s1_q  <= external_count_pin;
      ext_s2_q  <= ext_s1_q;
      ext_s3_q  <= ext_s2_q;
    end
  end

  assign rd_data              = rd_data_q;
  assign irq_overflow         = irq_q[OVF_BIT];
  assign irq_compare_a        = irq_q[CMPA_BIT];
  assign irq_compare_b        = irq_q[CMPB_BIT];
  assign compare_a_output_pin = wave_q[0];
  assign compare_b_output_pin = wave_q[1];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_force_reads_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_en && addr == OFF_CTRL_B) |=> rd_data[7:4] == 4'h0;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("control B upper bits read nonzero");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_en && (addr == OFF_MASK || addr == OFF_FLAGS)) |=> rd_data[7:3] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("mask or flag reserved bits read nonzero");

  property p_force_toggles;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_ctrl_b && wr_data[FORCE_A_BIT] && non_pwm && com_a_q == 2'b01 && !hit_a)
        |=> compare_a_output_pin != $past(compare_a_output_pin);
  endproperty
  a_force_toggles: assert property (p_force_toggles)
    else $error("forced compare A did not toggle output");

  property p_force_no_flag;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_ctrl_b && wr_data[FORCE_B_BIT] && !hit_b && !flags_q[CMPB_BIT])
        |=> !flags_q[CMPB_BIT];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag)
    else $error("forced compare B set a flag");

  property p_write_blocks_match;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_cnt ##1 (tick && !wr_cnt) |-> !hit_a && !hit_b;
  endproperty
  a_write_blocks_match: assert property (p_write_blocks_match)
    else $error("match not blocked after counter write");

  property p_stopped;
    @(posedge sys_clk) disable iff (!rst_n)
      (cs_q == CS_STOP && !wr_cnt) |=> cnt_q == $past(cnt_q);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  property p_ext_rise;
    @(posedge sys_clk) disable iff (!rst_n)
      (cs_q == CS_EXT_RISE && ext_s1_q && !ext_s2_q && $stable(cs_q) && !wr_ctrl_b) |=> tick;
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("rising pin edge did not clock the counter");

  property p_match_sets;
    @(posedge sys_clk) disable iff (!rst_n)
      hit_a |=> flags_q[CMPA_BIT] ##1 (irq_compare_a == $past(mask_q[CMPA_BIT] && global_interrupt_enable));
  endproperty
  a_match_sets: assert property (p_match_sets)
    else $error("compare A flag or request wrong after match");

  property p_w1c;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_flags && wr_data[OVF_BIT] && !ovf_evt) |=> !flags_q[OVF_BIT];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("overflow flag not cleared by write of one");

endmodule // timer8_core

// >>> hdl/timer8_pkg.sv
package timer8_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL_A  = 8'h30;
  localparam logic [7:0] OFF_COUNTER = 8'h32;
  localparam logic [7:0] OFF_CTRL_B  = 8'h33;
  localparam logic [7:0] OFF_CMP_A   = 8'h36;
  localparam logic [7:0] OFF_FLAGS   = 8'h38;
  localparam logic [7:0] OFF_MASK    = 8'h39;
  localparam logic [7:0] OFF_CMP_B   = 8'h3C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WGM2_BIT    = 3;
  localparam int CS_LSB      = 0;
  localparam int COM_A_LSB   = 6;
  localparam int COM_B_LSB   = 4;
  localparam int WGM_LOW_LSB = 0;
  localparam int OVF_BIT     = 0;
  localparam int CMPA_BIT    = 1;
  localparam int CMPB_BIT    = 2;

  // ----------------------------------------
  // values
  // ----------------------------------------
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] CNT_MAX   = 8'hFF;
  localparam logic [7:0] CNT_BOT   = 8'h00;
  localparam int         PRE_W     = 10;
  localparam logic [9:0] DIV8_MASK    = 10'h007;
  localparam logic [9:0] DIV64_MASK   = 10'h03F;
  localparam logic [9:0] DIV256_MASK  = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;

  typedef enum logic [2:0] {
    CS_STOP  = 3'b000, CS_DIV1   = 3'b001, CS_DIV8  = 3'b010, CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
  } clk_sel_e;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000, MODE_PC_FF = 3'b001, MODE_CTC = 3'b010, MODE_FAST_FF = 3'b011,
    MODE_RSV4 = 3'b100, MODE_PC_TOP = 3'b101, MODE_RSV6 = 3'b110, MODE_FAST_TOP = 3'b111
  } wave_mode_e;

endpackage

// >>> test/timer8_control_and_interrupts_bench.sv
`timescale 1ns/10ps
module timer8_control_and_interrupts_bench
  import timer8_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       sys_clk;
  logic       rst_n;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rd_data;
  logic       external_count_pin;
  logic       global_interrupt_enable;
  logic [2:0] vector_ack;
  logic       irq_overflow;
  logic       irq_compare_a;
  logic       irq_compare_b;
  logic       compare_a_output_pin;
  logic       compare_b_output_pin;
  int         error_cnt;
  int         check_count;
  int         cycle_cnt;

  timer8_core uut (
    .sys_clk                 (sys_clk),
    .rst_n                   (rst_n),
    .addr                    (addr),
    .wr_data                 (wr_data),
    .wr_en                   (wr_en),
    .rd_en                   (rd_en),
    .rd_data                 (rd_data),
    .external_count_pin      (external_count_pin),
    .global_interrupt_enable (global_interrupt_enable),
    .vector_ack              (vector_ack),
    .irq_overflow            (irq_overflow),
    .irq_compare_a           (irq_compare_a),
    .irq_compare_b           (irq_compare_b),
    .compare_a_output_pin    (compare_a_output_pin),
    .compare_b_output_pin    (compare_b_output_pin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results();
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000) begin
      error_cnt = error_cnt + 1;
      results();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    rd(a, d);
    check(d, exp, msg);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_and_reserved();
    rd_chk(OFF_CTRL_B, 8'h00, "ctrl b reset");
    rd_chk(OFF_MASK, 8'h00, "mask reset");
    rd_chk(OFF_FLAGS, 8'h00, "flags reset");
    wr(OFF_CTRL_B, 8'h38);
    rd_chk(OFF_CTRL_B, 8'h08, "ctrl b reserved");
    wr(OFF_MASK, 8'hFF);
    rd_chk(OFF_MASK, 8'h07, "mask reserved");
    wr(OFF_MASK, 8'h00);
    wr(OFF_CTRL_B, 8'h00);
    rd_chk(OFF_FLAGS, 8'h00, "flags reserved");
    wr(OFF_COUNTER, 8'hA5);
    rd_chk(OFF_COUNTER, 8'hA5, "counter rw");
  endtask

  task automatic t_prescale();
    logic [7:0] c0;
    logic [7:0] c1;
    int         span [6] = '{64, 64, 64, 256, 1024, 2048};
    logic [7:0] inc  [6] = '{8'h00, 8'h40, 8'h08, 8'h04, 8'h04, 8'h02};
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CTRL_B, 8'(i));
      rd(OFF_COUNTER, c0);
      repeat (span[i] - 2) @(posedge sys_clk);
      rd(OFF_COUNTER, c1);
      check(c1 - c0, inc[i], "prescaled count step");
    end
    wr(OFF_CTRL_B, 8'h00);
  endtask

  task automatic t_external();
    for (int s = 0; s < 2; s++) begin
      wr(OFF_COUNTER, 8'h00);
      wr(OFF_CTRL_B, s == 0 ? 8'h07 : 8'h06);
      repeat (5) begin
        external_count_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        external_count_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
      end
      repeat (6) @(posedge sys_clk);
      rd_chk(OFF_COUNTER, 8'h05, "external edge count");
    end
    wr(OFF_CTRL_B, 8'h00);
  endtask

  task automatic t_match_irq();
    wr(OFF_CMP_A, 8'h10);
    wr(OFF_CMP_B, 8'h20);
    wr(OFF_COUNTER, 8'h00);
    wr(OFF_FLAGS, 8'h07);
    wr(OFF_MASK, 8'h07);
    global_interrupt_enable <= 1'b1;
    wr(OFF_CTRL_B, 8'h01);
    repeat (300) @(posedge sys_clk);
    wr(OFF_CTRL_B, 8'h00);
    rd_chk(OFF_FLAGS, 8'h07, "match and overflow flags");
    check(8'({irq_compare_b, irq_compare_a, irq_overflow}), 8'h07, "irq all");
    wr(OFF_MASK, 8'h06);
    repeat (2) @(posedge sys_clk);
    check(8'({irq_compare_b, irq_compare_a, irq_overflow}), 8'h06, "irq masked");
    global_interrupt_enable <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(8'({irq_compare_b, irq_compare_a, irq_overflow}), 8'h00, "irq global off");
    wr(OFF_FLAGS, 8'h02);
    rd_chk(OFF_FLAGS, 8'h05, "write one clears");
    wr(OFF_FLAGS, 8'h00);
    rd_chk(OFF_FLAGS, 8'h05, "write zero keeps");
    vector_ack <= 3'b001;
    @(posedge sys_clk);
    vector_ack <= 3'b000;
    @(posedge sys_clk);
    rd_chk(OFF_FLAGS, 8'h04, "vector clears");
    wr(OFF_MASK, 8'h00);
  endtask

  task automatic t_force();
    logic       pa;
    logic       pb;
    logic [7:0] c0;
    wr(OFF_CTRL_A, 8'h52);
    wr(OFF_CMP_A, 8'h33);
    wr(OFF_COUNTER, 8'h33);
    wr(OFF_FLAGS, 8'h07);
    rd(OFF_COUNTER, c0);
    pa = compare_a_output_pin;
    pb = compare_b_output_pin;
    wr(OFF_CTRL_B, 8'hC0);
    repeat (2) @(posedge sys_clk);
    check(8'(compare_a_output_pin), 8'(!pa), "forced a toggles");
    check(8'(compare_b_output_pin), 8'(!pb), "forced b toggles");
    rd_chk(OFF_FLAGS, 8'h00, "force sets no flag");
    rd_chk(OFF_COUNTER, c0, "force keeps counter");
    rd_chk(OFF_CTRL_B, 8'h00, "force bits read zero");
    wr(OFF_CTRL_A, 8'h00);
  endtask

  task automatic t_write_block();
    wr(OFF_CMP_A, 8'h40);
    wr(OFF_COUNTER, 8'h40);
    wr(OFF_FLAGS, 8'h07);
    wr(OFF_CTRL_B, 8'h01);
    repeat (10) @(posedge sys_clk);
    wr(OFF_CTRL_B, 8'h00);
    rd_chk(OFF_FLAGS, 8'h00, "match after write blocked");
  endtask

  // clear on match, then fast pwm with top from compare a
  task automatic t_modes();
    logic [7:0] mode_a [2] = '{8'h02, 8'h03};
    logic [7:0] run_b  [2] = '{8'h01, 8'h09};
    logic [7:0] flg    [2] = '{8'h02, 8'h03};
    wr(OFF_CMP_A, 8'h09);
    for (int m = 0; m < 2; m++) begin
      wr(OFF_CTRL_A, mode_a[m]);
      wr(OFF_COUNTER, 8'h00);
      wr(OFF_FLAGS, 8'h07);
      wr(OFF_CTRL_B, run_b[m]);
      repeat (20) @(posedge sys_clk);
      wr(OFF_CTRL_B, run_b[m] & 8'h08);
      rd_chk(OFF_COUNTER, 8'h02, "top wraps counter");
      rd_chk(OFF_FLAGS, flg[m], "mode dependent overflow");
    end
    wr(OFF_CTRL_B, 8'h00);
    wr(OFF_CTRL_A, 8'h00);
  endtask

  task automatic t_reset_mid();
    wr(OFF_MASK, 8'h07);
    wr(OFF_CTRL_B, 8'h0A);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(OFF_CTRL_B, 8'h00, "ctrl b after reset");
    rd_chk(OFF_MASK, 8'h00, "mask after reset");
    rd_chk(OFF_FLAGS, 8'h00, "flags after reset");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n                   = 1'b0;
    addr                    = 8'h00;
    wr_data                 = 8'h00;
    wr_en                   = 1'b0;
    rd_en                   = 1'b0;
    external_count_pin      = 1'b0;
    global_interrupt_enable = 1'b0;
    vector_ack              = 3'b000;
    error_cnt               = 0;
    check_count             = 0;
    cycle_cnt               = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset_and_reserved();
    t_prescale();
    t_external();
    t_match_irq();
    t_force();
    t_write_block();
    t_modes();
    t_reset_mid();
    results();
  end
endmodule // timer8_control_and_interrupts_bench
